// ### src/isf_slave.sv
// two-wire slave front end: conditions, byte shifting, acknowledge, power-up hold
`timescale 1ns/1ps
`include "isf_params.svh"
// How it works
// - data falling while clock high starts a transaction
// - data rising while clock high ends a transaction
// - data line changes only while the clock is low
// - bus busy from start until stop
// - every byte is exactly eight bits
// - each byte plus acknowledge takes nine clock periods
// - bytes shift most significant bit first
// - no limit on bytes between start and stop
// - slave only; clock line is input only
// - data line is only pulled low or released
// - sampling keeps up with one megabit per second
// - fixed bus position, zero or seven, instead of select pins
// - during power-on reset all bus activity is ignored
// - standby entered after the power-up delay of 250 us
// - upper control nibble 1010 selects memory, 1011 security registers
// - respond only when three select bits match the fixed position: 000, or 111 with POS_SEVEN
// - last control bit: one reads, zero writes
// - acknowledge by pulling data low during ninth clock
module isf_slave #(
   parameter bit POS_SEVEN = 1'b0,
   parameter int PUD_CYCLES = `ISF_PUD_CYCLES
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic resetn,
   // bus pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // user side
   input wire logic [7:0] tx_data,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_first,
   output logic sec_sel,
   output logic rd_mode,
   output logic tx_load,
   output logic master_nack,
   output logic bus_busy,
   output logic ready
);
   // ------------------------------------------------
   // synchronisers and glitch filter
   // ------------------------------------------------
   logic scl_s1_reg, scl_s2_reg, sda_s1_reg, sda_s2_reg;
   logic [2:0] scl_h_reg, sda_h_reg;
   logic scl_f_reg, sda_f_reg, scl_p_reg, sda_p_reg;

   function automatic logic filt(input logic [2:0] h, input logic cur);
      filt = (&h) ? 1'b1 : ((~|h) ? 1'b0 : cur);
   endfunction

   // clock pin is sampled only, never driven
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         scl_s1_reg <= 1'b1;
         scl_s2_reg <= 1'b1;
         sda_s1_reg <= 1'b1;
         sda_s2_reg <= 1'b1;
         scl_h_reg <= 3'h7;
         sda_h_reg <= 3'h7;
         scl_f_reg <= 1'b1;
         sda_f_reg <= 1'b1;
         scl_p_reg <= 1'b1;
         sda_p_reg <= 1'b1;
      end else begin
         scl_s1_reg <= scl_in;
         scl_s2_reg <= scl_s1_reg;
         sda_s1_reg <= sda_in;
         sda_s2_reg <= sda_s1_reg;
         // three agreeing samples: 75 ns, far below a 1 Mbit/s half period
         scl_h_reg <= {scl_h_reg[1:0], scl_s2_reg};
         sda_h_reg <= {sda_h_reg[1:0], sda_s2_reg};
         scl_f_reg <= filt(scl_h_reg, scl_f_reg);
         sda_f_reg <= filt(sda_h_reg, sda_f_reg);
         scl_p_reg <= scl_f_reg;
         sda_p_reg <= sda_f_reg;
      end
   end

   logic scl_rise, scl_fall, start_evt, stop_evt;
   assign scl_rise = scl_f_reg && !scl_p_reg;
   assign scl_fall = !scl_f_reg && scl_p_reg;
   assign start_evt = ready && scl_f_reg && scl_p_reg && sda_p_reg && !sda_f_reg;
   assign stop_evt = ready && scl_f_reg && scl_p_reg && !sda_p_reg && sda_f_reg;

   // ------------------------------------------------
   // power-up hold
   // ------------------------------------------------
   logic [31:0] pud_cnt_reg;
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         pud_cnt_reg <= 32'h0;
         ready <= 1'b0;
      end else if (!ready) begin
         // standby only once the delay has run out
         if (pud_cnt_reg >= 32'(PUD_CYCLES - 1)) begin
            ready <= 1'b1;
         end
         pud_cnt_reg <= pud_cnt_reg + 32'h1;
      end
   end

   // ------------------------------------------------
   // bus occupancy
   // ------------------------------------------------
   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         bus_busy <= 1'b0;
      end else if (start_evt) begin
         bus_busy <= 1'b1;
      end else if (stop_evt) begin
         bus_busy <= 1'b0;
      end
   end

   // ------------------------------------------------
   // byte engine
   // ------------------------------------------------
   isf_pkg::isf_state_t state_reg;
   logic [3:0] bit_cnt_reg;
   logic [7:0] rx_sh_reg, tx_sh_reg;
   logic ack_seen_reg;
   logic [2:0] own_sel;
   assign own_sel = POS_SEVEN ? `ISF_SEL_SEVEN : `ISF_SEL_ZERO;
   logic code_ok, sel_ok;
   assign code_ok = (rx_sh_reg[7:4] == `ISF_CODE_MEM) || (rx_sh_reg[7:4] == `ISF_CODE_SEC);
   assign sel_ok = rx_sh_reg[3:1] == own_sel;

   always_ff @(posedge core_clk) begin
      if (!resetn) begin
         sda_out <= 1'b0;
         sda_oe <= 1'b0;
         state_reg <= isf_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         rx_sh_reg <= 8'h00;
         tx_sh_reg <= 8'h00;
         ack_seen_reg <= 1'b0;
         rx_data <= 8'h00;
         rx_valid <= 1'b0;
         rx_first <= 1'b0;
         sec_sel <= 1'b0;
         rd_mode <= 1'b0;
         tx_load <= 1'b0;
         master_nack <= 1'b0;
      end else begin
         rx_valid <= 1'b0;
         tx_load <= 1'b0;
         master_nack <= 1'b0;
         // output level stays 0: only pull low or release
         sda_out <= 1'b0;
         if (!ready) begin
            state_reg <= isf_pkg::ST_IDLE;
            sda_oe <= 1'b0;
         end else if (start_evt) begin
            // repeated start also lands here, from any state
            state_reg <= isf_pkg::ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe <= 1'b0;
         end else if (stop_evt) begin
            state_reg <= isf_pkg::ST_IDLE;
            sda_oe <= 1'b0;
         end else begin
            unique case (state_reg)
               isf_pkg::ST_IDLE: begin
                  sda_oe <= 1'b0;
               end
               isf_pkg::ST_ADDR, isf_pkg::ST_WR: begin
                  if (scl_rise) begin
                     rx_sh_reg <= {rx_sh_reg[6:0], sda_f_reg};
                     bit_cnt_reg <= bit_cnt_reg + 4'h1;
                  end else if (scl_fall && bit_cnt_reg == `ISF_BYTE_BITS) begin
                     bit_cnt_reg <= 4'h0;
                     rx_data <= rx_sh_reg;
                     if (state_reg == isf_pkg::ST_WR) begin
                        rx_valid <= 1'b1;
                        rx_first <= 1'b0;
                        sda_oe <= 1'b1;
                        state_reg <= isf_pkg::ST_ACK_WR;
                     end else if (code_ok && sel_ok) begin
                        rx_valid <= 1'b1;
                        rx_first <= 1'b1;
                        sec_sel <= rx_sh_reg[4];
                        rd_mode <= rx_sh_reg[0];
                        sda_oe <= 1'b1;
                        state_reg <= isf_pkg::ST_ACK_ADR;
                     end else begin
                        state_reg <= isf_pkg::ST_IDLE;
                     end
                  end
               end
               isf_pkg::ST_ACK_ADR, isf_pkg::ST_ACK_WR: begin
                  // ninth clock ends on its falling edge
                  if (scl_fall) begin
                     if (state_reg == isf_pkg::ST_ACK_ADR && rd_mode) begin
                        tx_sh_reg <= {tx_data[6:0], 1'b0};
                        sda_oe <= !tx_data[7];
                        tx_load <= 1'b1;
                        bit_cnt_reg <= 4'h1;
                        state_reg <= isf_pkg::ST_RD;
                     end else begin
                        sda_oe <= 1'b0;
                        bit_cnt_reg <= 4'h0;
                        state_reg <= isf_pkg::ST_WR;
                     end
                  end
               end
               isf_pkg::ST_RD: begin
                  // new bit only after the falling edge
                  if (scl_fall) begin
                     if (bit_cnt_reg == `ISF_BYTE_BITS) begin
                        sda_oe <= 1'b0;
                        state_reg <= isf_pkg::ST_ACK_RD;
                     end else begin
                        sda_oe <= !tx_sh_reg[7];
                        tx_sh_reg <= {tx_sh_reg[6:0], 1'b0};
                        bit_cnt_reg <= bit_cnt_reg + 4'h1;
                     end
                  end
               end
               isf_pkg::ST_ACK_RD: begin
                  if (scl_rise) begin
                     ack_seen_reg <= !sda_f_reg;
                  end else if (scl_fall) begin
                     if (ack_seen_reg) begin
                        tx_sh_reg <= {tx_data[6:0], 1'b0};
                        sda_oe <= !tx_data[7];
                        tx_load <= 1'b1;
                        bit_cnt_reg <= 4'h1;
                        state_reg <= isf_pkg::ST_RD;
                     end else begin
                        master_nack <= 1'b1;
                        state_reg <= isf_pkg::ST_IDLE;
                     end
                  end
               end
            endcase
         end
      end
   end

   // ------------------------------------------------
   // assertions
   // ------------------------------------------------
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn);
   property p_start;
      start_evt |=> state_reg == isf_pkg::ST_ADDR && !sda_oe;
   endproperty
   a_start: assert property (p_start) else $error("start not taken");
   property p_stop;
      stop_evt |=> state_reg == isf_pkg::ST_IDLE && !sda_oe && !bus_busy;
   endproperty
   a_stop: assert property (p_stop) else $error("stop not taken");
   property p_stable_high;
      (scl_f_reg && scl_p_reg && !$past(start_evt) && !$past(stop_evt)) |-> $stable(sda_oe);
   endproperty
   a_stable_high: assert property (p_stable_high) else $error("data moved with clock high");
   property p_busy_hold;
      (bus_busy && !stop_evt) |=> bus_busy;
   endproperty
   a_busy_hold: assert property (p_busy_hold) else $error("busy dropped without stop");
   property p_pull_only;
      !sda_out;
   endproperty
   a_pull_only: assert property (p_pull_only) else $error("data line driven high");
   property p_por;
      !ready |-> state_reg == isf_pkg::ST_IDLE && !sda_oe && !rx_valid;
   endproperty
   a_por: assert property (p_por) else $error("activity during power-up");
   property p_pud;
      $rose(ready) |-> pud_cnt_reg == 32'(PUD_CYCLES);
   endproperty
   a_pud: assert property (p_pud) else $error("power-up delay wrong");
   property p_ack;
      (state_reg == isf_pkg::ST_ACK_ADR || state_reg == isf_pkg::ST_ACK_WR) |-> sda_oe;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge not driven");
   // every accepted control byte, repeated starts included
   property p_match;
      (rx_valid && rx_first) |-> rx_data[3:1] == own_sel && rx_data[7:5] == 3'h5;
   endproperty
   a_match: assert property (p_match) else $error("foreign address accepted");
   property p_first_ack;
      (rx_valid && rx_first) |-> state_reg == isf_pkg::ST_ACK_ADR ##0 rd_mode == rx_data[0];
   endproperty
   a_first_ack: assert property (p_first_ack) else $error("direction not kept");
   c_start: cover property (start_evt);
   c_addr_ok: cover property (rx_valid && rx_first);
   c_read: cover property (tx_load ##[1:1000] tx_load);
   c_nack: cover property (master_nack);
endmodule

// ### inc/isf_params.svh
// constants of the two-wire slave front end
`ifndef ISF_PARAMS_SVH
`define ISF_PARAMS_SVH
`define ISF_CLK_MHZ 40
`define ISF_PUD_US 250
`define ISF_PUD_CYCLES (`ISF_PUD_US * `ISF_CLK_MHZ)
`define ISF_CODE_MEM 4'ha
`define ISF_CODE_SEC 4'hb
`define ISF_SEL_ZERO 3'h0
`define ISF_SEL_SEVEN 3'h7
`define ISF_BYTE_BITS 4'h8
`endif

// ### inc/isf_pkg.sv
// types of the two-wire slave front end
package isf_pkg;
   typedef enum logic [6:0] {
      ST_IDLE    = 7'h01,
      ST_ADDR    = 7'h02,
      ST_ACK_ADR = 7'h04,
      ST_WR      = 7'h08,
      ST_ACK_WR  = 7'h10,
      ST_RD      = 7'h20,
      ST_ACK_RD  = 7'h40
   } isf_state_t;
endpackage

// ### tb/isf_master_model.sv
// bus master model that drives the two-wire slave from the far side
`timescale 1ns/1ps
module isf_master_model (
   // clock used to pace the bus
   input wire logic core_clk,
   // bus
   input wire logic sda,
   output logic scl,
   output logic m_oe
);
   // 200 ns steps; the slave answers about seven core cycles after a fall,
   // so the clock stays low for two steps and the answer settles before the rise
   localparam int H = 8;
   // clock stands high between frames, data released
   initial begin
      scl = 1'b1;
      m_oe = 1'b0;
   end
   task automatic hw();
      repeat (H) @(posedge core_clk);
   endtask
   // only this side makes start and stop
   task automatic start();
      m_oe <= 1'b0;
      hw();
      scl <= 1'b1;
      hw();
      m_oe <= 1'b1;
      hw();
      scl <= 1'b0;
      hw();
   endtask
   task automatic stop();
      m_oe <= 1'b1;
      hw();
      scl <= 1'b1;
      hw();
      m_oe <= 1'b0;
      hw();
      hw();
   endtask
   // data moves only while the clock is low, pulled low or released
   task automatic bit_io(input logic b, output logic s);
      m_oe <= !b;
      hw();
      scl <= 1'b1;
      hw();
      s = sda;
      scl <= 1'b0;
      hw();
   endtask
   // eight bits msb first, then the ninth acknowledge bit
   task automatic byte_io(input logic [7:0] d, input logic nine, output logic [7:0] r,
                          output logic a);
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r[i]);
      end
      bit_io(nine, a);
   endtask
endmodule

// ### tb/isf_slave_tb_top.sv
// bench top for the two-wire slave front end
`timescale 1ns/1ps
module isf_slave_tb_top;
   localparam int PUD = 400;
   logic core_clk, resetn, scl, m_oe, sda, sda_out, sda_oe, rx_valid, rx_first, sec_sel;
   logic rd_mode, tx_load, master_nack, bus_busy, ready, got_first;
   logic [7:0] tx_data, rx_data, got_rx;
   int fails = 0, n_checks = 0, n_rx = 0, n_nack = 0;
   // released wire floats high through the pull-up
   assign sda = !(sda_oe | m_oe);
   isf_slave #(.POS_SEVEN(1'b0), .PUD_CYCLES(PUD)) u_isf_slave (
      .core_clk(core_clk), .resetn(resetn), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .tx_data(tx_data), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_first(rx_first), .sec_sel(sec_sel), .rd_mode(rd_mode), .tx_load(tx_load),
      .master_nack(master_nack), .bus_busy(bus_busy), .ready(ready));
   isf_master_model u_isf_master_model (.core_clk(core_clk), .sda(sda), .scl(scl), .m_oe(m_oe));
   initial begin
      core_clk = 1'b0;
      forever #12.5 core_clk = ~core_clk;
   end
   // user side: capture pulses, flip the byte offered on every load
   always @(posedge core_clk) begin
      if (rx_valid) begin
         got_rx <= rx_data;
         got_first <= rx_first;
         n_rx <= n_rx + 1;
      end
      if (master_nack) n_nack <= n_nack + 1;
      if (tx_load) tx_data <= ~tx_data;
   end
   task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
      n_checks++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", what, e, g);
      end
   endtask
   task automatic send(input logic [7:0] d, output logic a);
      logic [7:0] r;
      u_isf_master_model.byte_io(d, 1'b1, r, a);
   endtask
   task automatic t_powerup();
      logic a;
      chk("oe_rst", 8'h0, {7'h0, sda_oe});
      resetn <= 1'b1;
      u_isf_master_model.start();
      send(8'ha0, a);
      chk("ack_early", 8'h1, {7'h0, a});
      u_isf_master_model.stop();
      chk("rx_early", 8'h0, n_rx[7:0]);
      chk("rdy_early", 8'h0, {7'h0, ready});
      for (int i = 0; i < PUD && ready !== 1'b1; i++) @(posedge core_clk);
      chk("rdy", 8'h1, {7'h0, ready});
   endtask
   task automatic t_write();
      logic a;
      logic [7:0] d[4] = '{8'h5a, 8'h81, 8'h3c, 8'hff};
      u_isf_master_model.start();
      chk("busy", 8'h1, {7'h0, bus_busy});
      send(8'ha0, a);
      chk("ack_ctl", 8'h0, {7'h0, a});
      chk("ctl", 8'ha0, got_rx);
      chk("first", 8'h1, {7'h0, got_first});
      chk("dir", 8'h0, {6'h0, sec_sel, rd_mode});
      foreach (d[i]) begin
         send(d[i], a);
         chk("ack_dat", 8'h0, {7'h0, a});
         chk("rx_dat", d[i], got_rx);
         chk("first_dat", 8'h0, {7'h0, got_first});
      end
      u_isf_master_model.stop();
      chk("idle", 8'h0, {7'h0, bus_busy});
   endtask
   task automatic t_reject();
      logic a;
      logic [7:0] c[3] = '{8'ha2, 8'hae, 8'h90};
      int n0 = n_rx;
      foreach (c[i]) begin
         u_isf_master_model.start();
         send(c[i], a);
         chk("nack_ctl", 8'h1, {7'h0, a});
         send(8'h00, a);
         chk("nack_dat", 8'h1, {7'h0, a});
         u_isf_master_model.stop();
      end
      chk("rx_rej", n0[7:0], n_rx[7:0]);
   endtask
   task automatic t_read();
      logic a;
      logic [7:0] r;
      u_isf_master_model.start();
      send(8'ha0, a);
      u_isf_master_model.start();
      send(8'hb1, a);
      chk("ack_rs", 8'h0, {7'h0, a});
      chk("dir_rd", 8'h3, {6'h0, sec_sel, rd_mode});
      u_isf_master_model.byte_io(8'hff, 1'b0, r, a);
      chk("rd0", 8'hc5, r);
      u_isf_master_model.byte_io(8'hff, 1'b1, r, a);
      chk("rd1", 8'h3a, r);
      // the nack pulse is counted eight cycles after the ninth fall, on the edge the byte ends: look after the stop
      u_isf_master_model.stop();
      chk("mnack", 8'h1, n_nack[7:0]);
   endtask
   task automatic complete_run();
      $display("checks %0d fails %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      resetn = 1'b0;
      tx_data = 8'hc5;
      repeat (3) @(posedge core_clk);
      t_powerup();
      t_write();
      t_reject();
      t_read();
      complete_run();
   end
   // about 4000 cycles of traffic expected
   initial begin
      repeat (40000) @(posedge core_clk);
      fails++;
      complete_run();
   end
endmodule
